// file: src/urcg_encode.sv
// Builds the status byte from the present line, comparator and event levels.
// Assumes all inputs are already in the clock domain of the caller.
module urcg_encode (
	input  wire logic       hs_mode_in,
	input  wire logic       ls_mode_in,
	input  wire logic       otg_en_in,
	input  wire logic       dp_in,
	input  wire logic       dm_in,
	input  wire logic       squelch_in,
	input  wire logic       session_end_flag_in,
	input  wire logic       session_valid_flag_in,
	input  wire logic       vbus_valid_flag_in,
	input  wire logic       id_in,
	input  wire logic       rx_active_in,
	input  wire logic       rx_error_in,
	input  wire logic       host_disconnect_event_in,
	input  wire logic       alt_int_in,
	output logic      [1:0] line_out,
	output logic            line_idle_out,
	output logic      [7:0] cmd_out
);
	logic [1:0] vbus;
	logic [1:0] evt;

	always_comb begin
		if (hs_mode_in) begin
			line_out = squelch_in ? urcg_pkg::LINE_SE0 : urcg_pkg::LINE_J;
		end else begin
			line_out = {dm_in, dp_in};
		end
		// Low speed idles in K because the hub repeater inverts the lines.
		line_idle_out = (line_out ==
			(ls_mode_in ? urcg_pkg::LINE_K : urcg_pkg::LINE_J));
		if (vbus_valid_flag_in) begin
			vbus = urcg_pkg::VBUS_ABOVE_VLD;
		end else if (!otg_en_in) begin
			vbus = urcg_pkg::VBUS_BELOW_END;
		end else if (session_valid_flag_in) begin
			vbus = urcg_pkg::VBUS_SES_TO_VLD;
		end else if (session_end_flag_in) begin
			vbus = urcg_pkg::VBUS_BELOW_END;
		end else begin
			vbus = urcg_pkg::VBUS_END_TO_SES;
		end
		if (host_disconnect_event_in) begin
			evt = urcg_pkg::EVT_HOST_DISCONNECT_EVENT;
		end else if (rx_active_in) begin
			evt = rx_error_in ? urcg_pkg::EVT_ERROR : urcg_pkg::EVT_ACTIVE;
		end else begin
			evt = urcg_pkg::EVT_NONE;
		end
		cmd_out = {alt_int_in, id_in & otg_en_in, evt, vbus, line_out};
	end
endmodule // urcg_encode

// file: src/urcg_main.sv
// Status byte generator on the transceiver side of the 8-bit link bus,
// with an APB register slave for control, status and the interrupt latch.
// Assumes the link, the transmit path and the receive path share clk_in.
//
// Function
// (R1) Status byte only while bus idle; DIR asserted first to own bus.
// (R2) Status bytes go out synchronously while the device owns the bus.
// (R3) One or several consecutive status bytes per bus ownership period.
// (R4) Byte carries line state, receive events and VBUS valid.
// (R5) With OTG enabled, byte also carries VBUS level and ID pin.
// (R6) Any change of decoded line state schedules a status byte.
// (R7) Any VBUS or ID comparator change schedules a status byte.
// (R8) During receive, status byte in each cycle with DIR high, NXT low.
// (R9) After start-up DIR release, status byte sent once STP low.
// (R10) On leaving async modes, byte sent after STP low and DIR low.
// (R11) During transmit, status bytes held until STP ends the transmit.
// (R12) Events during high-speed transmit wait until STP deasserts.
// (R13) Each byte shows conditions current when it is driven.
// (R14) Bits one to zero carry the line state.
// (R15) Bits three to two encode the VBUS level band.
// (R16) Bits five to four encode receive events and host disconnect.
// (R17) Bit six follows the ID pin: low A-side, high B-side.
// (R18) Bit seven set by any unmasked interrupt latch event.
// (R19) Link reads the interrupt latch on seeing bit seven set.
// (R20) Full/low speed line state comes from single-ended receivers.
// (R21) High speed line state: 00 squelch, 01 squelch released.
// (R22) Full speed: receive-active stays reported until lines idle.
// (R23) DIR assertion cycle is turnaround; byte valid the next cycle.
//
// Local design decisions: the APB slave port and the register addresses.
module urcg_main (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        stp_in,
	input  wire logic  [7:0] data_in,
	output logic             dir_out,
	output logic             nxt_out,
	output logic       [7:0] data_out,
	output logic             data_oe_out,
	input  wire logic        dp_se_in,
	input  wire logic        dm_se_in,
	input  wire logic        squelch_in,
	input  wire logic        session_end_flag_in,
	input  wire logic        session_valid_flag_in,
	input  wire logic        vbus_valid_flag_in,
	input  wire logic        id_in,
	input  wire logic        rx_active_in,
	input  wire logic        rx_error_in,
	input  wire logic        rx_data_valid_in,
	input  wire logic  [7:0] rx_data_in,
	input  wire logic        host_disconnect_event_in,
	input  wire logic        tx_busy_in,
	input  wire logic        id_resistance_conversion_done_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic  [7:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out
);
	typedef struct packed {
		urcg_pkg::urcg_state_t state;
		logic [7:0]  cnt;
		logic        pend;
		logic        dir;
		logic        nxt;
		logic [7:0]  data;
		logic        oe;
		logic [4:0]  ctrl;
		logic        latch;
		logic [7:0]  last_cmd;
		logic [1:0]  prev_line;
		logic [4:0]  prev_cmp;
		logic        prev_hd;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} urcg_main_t;

	urcg_main_t s_reg;
	urcg_main_t s_next;

	logic [6:0] pins_sync;
	logic [1:0] line;
	logic       line_idle;
	logic [7:0] cmd;
	logic       rep_active;
	logic       alt_int;
	logic       ev;
	logic       send_ok;
	logic       apb_wr;
	logic       apb_setup;
	logic [4:0] cmp_now;

	// Pins from the analog front end are asynchronous to clk_in.
	urcg_sync #(
		.W(7)
	) u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.d_in  ({dp_se_in, dm_se_in, squelch_in, session_end_flag_in,
			session_valid_flag_in, vbus_valid_flag_in, id_in}),
		.q_out (pins_sync)
	);

	assign alt_int = s_reg.latch & s_reg.ctrl[urcg_pkg::CTRL_RIDMASK_BIT]; // R18
	assign cmp_now = pins_sync[4:0];

	// Full speed keeps receive-active reported until the lines go idle, so
	// the link cannot turn the bus round inside two bit times.
	assign rep_active = rx_active_in | // R22
		(~s_reg.ctrl[urcg_pkg::CTRL_HS_BIT] & (s_reg.state == urcg_pkg::ST_RECV)
		& ~line_idle);

	urcg_encode u_enc (
		.hs_mode_in              (s_reg.ctrl[urcg_pkg::CTRL_HS_BIT]),
		.ls_mode_in              (s_reg.ctrl[urcg_pkg::CTRL_LS_BIT]),
		.otg_en_in               (s_reg.ctrl[urcg_pkg::CTRL_OTG_BIT]),
		.dp_in                   (pins_sync[6]),
		.dm_in                   (pins_sync[5]),
		.squelch_in              (pins_sync[4]),
		.session_end_flag_in     (pins_sync[3]),
		.session_valid_flag_in   (pins_sync[2]),
		.vbus_valid_flag_in      (pins_sync[1]),
		.id_in                   (pins_sync[0]),
		.rx_active_in            (rep_active),
		.rx_error_in             (rx_error_in),
		.host_disconnect_event_in(host_disconnect_event_in),
		.alt_int_in              (alt_int),
		.line_out                (line),
		.line_idle_out           (line_idle),
		.cmd_out                 (cmd)
	); // R4 R5 R14 R15 R16 R17 R20 R21

	// A host disconnect is reported in a byte of its own, set and clear alike.
	assign ev = (line != s_reg.prev_line) | (cmp_now != s_reg.prev_cmp) |
		(host_disconnect_event_in != s_reg.prev_hd); // R6 R7
	// Bus must be idle, no transmit running and STP released.
	assign send_ok = s_reg.pend & ~tx_busy_in & ~stp_in & // R1 R11 R12
		(data_in == 8'h00);
	assign apb_setup = psel_in & ~penable_in;
	assign apb_wr = psel_in & penable_in & s_reg.pready & pwrite_in;

	always_comb begin
		s_next           = s_reg;
		s_next.prev_line = line;
		s_next.prev_cmp  = cmp_now;
		s_next.prev_hd   = host_disconnect_event_in;
		s_next.pend      = s_reg.pend | ev;
		if (ev || (alt_int && !s_reg.last_cmd[urcg_pkg::CMD_ALT_BIT])) begin
			s_next.pend = 1'b1;
		end
		unique case (s_reg.state)
			urcg_pkg::ST_START: begin
				s_next.cnt = s_reg.cnt + 8'h01;
				if (s_reg.cnt == 8'(urcg_pkg::STARTUP_CYCLES - 1)) begin
					s_next.state = urcg_pkg::ST_IDLE;
					s_next.dir   = 1'b0;
					s_next.pend  = 1'b1; // R9
				end
			end
			urcg_pkg::ST_IDLE: begin
				if (rx_active_in) begin
					// A packet takes priority; DIR and NXT rise together.
					s_next.state = urcg_pkg::ST_RECV;
					s_next.dir   = 1'b1;
					s_next.nxt   = 1'b1;
				end else if (s_reg.ctrl[urcg_pkg::CTRL_ASYNC_BIT]) begin
					s_next.state = urcg_pkg::ST_ASYNC;
					s_next.dir   = 1'b1;
				end else if (send_ok) begin
					s_next.state = urcg_pkg::ST_TURN; // R1
					s_next.dir   = 1'b1;
				end
			end
			urcg_pkg::ST_TURN: begin
				s_next.state = urcg_pkg::ST_SEND; // R23
				s_next.oe    = 1'b1;
				s_next.data  = cmd; // R13
				s_next.pend  = ev;
			end
			urcg_pkg::ST_SEND: begin
				if (rx_active_in) begin
					s_next.state = urcg_pkg::ST_RECV;
					s_next.nxt   = rx_data_valid_in;
					s_next.data  = rx_data_valid_in ? rx_data_in : cmd;
				end else if (s_reg.pend) begin
					s_next.data = cmd; // R3
					s_next.pend = ev;
				end else begin
					s_next.state = urcg_pkg::ST_IDLE;
					s_next.dir   = 1'b0;
					s_next.oe    = 1'b0;
				end
			end
			urcg_pkg::ST_RECV: begin
				s_next.oe = 1'b1;
				if (rx_data_valid_in) begin
					s_next.nxt  = 1'b1;
					s_next.data = rx_data_in;
				end else begin
					s_next.nxt  = 1'b0; // R8
					s_next.data = cmd; // R2
					s_next.pend = ev;
					if (!rep_active) begin
						s_next.state = urcg_pkg::ST_SEND;
					end
				end
			end
			urcg_pkg::ST_ASYNC: begin
				if (!s_reg.ctrl[urcg_pkg::CTRL_ASYNC_BIT] && !stp_in) begin
					s_next.state = urcg_pkg::ST_IDLE;
					s_next.dir   = 1'b0;
					s_next.pend  = 1'b1; // R10
				end
			end
			default: begin
				s_next.state = urcg_pkg::ST_IDLE;
				s_next.dir   = 1'b0;
				s_next.nxt   = 1'b0;
				s_next.oe    = 1'b0;
			end
		endcase
		if (s_next.oe && !s_next.nxt) begin
			s_next.last_cmd = s_next.data;
		end
		// Register slave: answer prepared in setup, given in the access cycle.
		s_next.pready  = apb_setup;
		s_next.pslverr = 1'b0;
		s_next.prdata  = 32'h0000_0000;
		if (apb_setup) begin
			unique case (paddr_in)
				urcg_pkg::CTRL_OFFSET:   s_next.prdata = {27'h0, s_reg.ctrl};
				urcg_pkg::STATUS_OFFSET: s_next.prdata = {22'h0, s_reg.dir,
					s_reg.pend, s_reg.last_cmd};
				urcg_pkg::LATCH_OFFSET:  s_next.prdata = {31'h0, s_reg.latch};
				default:                 s_next.pslverr = 1'b1;
			endcase
		end
		if (apb_wr && paddr_in == urcg_pkg::CTRL_OFFSET) begin
			s_next.ctrl = pwdata_in[urcg_pkg::CTRL_WIDTH-1:0];
		end
		// Write one to clear; a new conversion event in the same cycle wins.
		if (apb_wr && paddr_in == urcg_pkg::LATCH_OFFSET &&
			pwdata_in[urcg_pkg::LATCH_RID_BIT]) begin
			s_next.latch = 1'b0;
		end
		if (id_resistance_conversion_done_in) begin
			s_next.latch = 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_reg          <= '0;
			s_reg.state    <= urcg_pkg::ST_START;
			s_reg.dir      <= 1'b1;
			s_reg.ctrl     <= urcg_pkg::CTRL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign dir_out     = s_reg.dir;
	assign nxt_out     = s_reg.nxt;
	assign data_out    = s_reg.data;
	assign data_oe_out = s_reg.oe;
	assign prdata_out  = s_reg.prdata;
	assign pready_out  = s_reg.pready;
	assign pslverr_out = s_reg.pslverr;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	turnaround_gap_a: assert property ( // R23
		$rose(dir_out) && !nxt_out && s_reg.state == urcg_pkg::ST_TURN |->
		!data_oe_out ##1 data_oe_out && dir_out)
		else $error("status byte not valid right after turnaround");
	idle_bus_start_a: assert property ( // R1
		$rose(dir_out) && !nxt_out && s_reg.state == urcg_pkg::ST_TURN |->
		$past(data_in) == 8'h00 && !$past(stp_in))
		else $error("bus taken while link not idle");
	byte_is_current_a: assert property ( // R13
		data_oe_out && !nxt_out |-> data_out == $past(cmd))
		else $error("status byte does not show present conditions");
	recv_status_a: assert property ( // R8
		s_reg.state == urcg_pkg::ST_RECV && !rx_data_valid_in |=>
		dir_out && !nxt_out && data_oe_out)
		else $error("no status byte in receive gap");
	event_pends_a: assert property ( // R6
		ev |=> s_reg.pend || $past(s_reg.state) == urcg_pkg::ST_START)
		else $error("line or comparator change lost");
	tx_hold_a: assert property ( // R11
		s_reg.state == urcg_pkg::ST_IDLE && (tx_busy_in || stp_in) &&
		!rx_active_in && !s_reg.ctrl[urcg_pkg::CTRL_ASYNC_BIT] |=> !dir_out)
		else $error("status byte sent during transmit");
	startup_pend_a: assert property ( // R9
		$past(s_reg.state) == urcg_pkg::ST_START &&
		s_reg.state == urcg_pkg::ST_IDLE |-> s_reg.pend && !dir_out)
		else $error("no status byte scheduled after start-up");
	async_exit_a: assert property ( // R10
		$past(s_reg.state) == urcg_pkg::ST_ASYNC &&
		s_reg.state == urcg_pkg::ST_IDLE |-> s_reg.pend && !$past(stp_in))
		else $error("async exit without status byte");
	alt_flag_a: assert property ( // R18
		data_oe_out && !nxt_out |->
		data_out[urcg_pkg::CMD_ALT_BIT] == $past(alt_int))
		else $error("alternate interrupt flag missing");
	fs_active_a: assert property ( // R22
		s_reg.state == urcg_pkg::ST_RECV && !s_reg.ctrl[urcg_pkg::CTRL_HS_BIT]
		&& !line_idle |=> data_oe_out &&
		(nxt_out || data_out[5:4] != urcg_pkg::EVT_NONE))
		else $error("receive-active dropped before idle line");
	apb_answer_a: assert property (
		apb_setup |=> pready_out ##1 !pready_out || apb_setup)
		else $error("register access not answered in one cycle");

	// A byte on the bus was built one cycle earlier, so each field is held
	// against the levels of that cycle; this keeps the checks free of races.
	fs_line_a: assert property ( // R20
		data_oe_out && !nxt_out && !$past(s_reg.ctrl[urcg_pkg::CTRL_HS_BIT])
		|-> data_out[1:0] == {$past(pins_sync[5]), $past(pins_sync[6])})
		else $error("full speed line state wrong");
	hs_line_a: assert property ( // R21
		data_oe_out && !nxt_out && $past(s_reg.ctrl[urcg_pkg::CTRL_HS_BIT])
		|-> !data_out[1])
		else $error("invalid high speed line state");
	vbus_band_a: assert property ( // R15
		data_oe_out && !nxt_out && $past(pins_sync[1]) |->
		data_out[3:2] == urcg_pkg::VBUS_ABOVE_VLD)
		else $error("vbus valid not reported");
	id_follow_a: assert property ( // R17
		data_oe_out && !nxt_out && $past(s_reg.ctrl[urcg_pkg::CTRL_OTG_BIT])
		|-> data_out[urcg_pkg::CMD_ID_BIT] == $past(pins_sync[0]))
		else $error("id bit does not follow the pin");
	disconnect_evt_a: assert property ( // R16
		data_oe_out && !nxt_out && $past(host_disconnect_event_in) |->
		data_out[5:4] == urcg_pkg::EVT_HOST_DISCONNECT_EVENT)
		else $error("host disconnect not reported");
	pend_kept_a: assert property ( // R12
		s_reg.state == urcg_pkg::ST_IDLE && s_reg.pend && tx_busy_in |=>
		s_reg.pend)
		else $error("status byte lost during transmit");

	cmd_sent_c: cover property (s_reg.state == urcg_pkg::ST_TURN ##1
		s_reg.state == urcg_pkg::ST_SEND);
	back_to_back_c: cover property (s_reg.state == urcg_pkg::ST_SEND ##1
		s_reg.state == urcg_pkg::ST_SEND);
	receive_c: cover property (s_reg.state == urcg_pkg::ST_RECV && !nxt_out);
	async_exit_c: cover property (s_reg.state == urcg_pkg::ST_ASYNC ##1
		s_reg.state == urcg_pkg::ST_IDLE);
	disconnect_c: cover property (data_oe_out && !nxt_out &&
		data_out[5:4] == urcg_pkg::EVT_HOST_DISCONNECT_EVENT);
endmodule // urcg_main

// file: src/urcg_pkg.sv
// Constants, register map and state codes for the receive command generator.
// Assumes a single 50 MHz clock shared by the link side and the register bus.
package urcg_pkg;
	localparam int CLK_PERIOD_NS  = 20;
	localparam int STARTUP_NS     = 200;
	localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;

	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] LATCH_OFFSET  = 8'h08;

	localparam int CTRL_HS_BIT      = 0;
	localparam int CTRL_LS_BIT      = 1;
	localparam int CTRL_OTG_BIT     = 2;
	localparam int CTRL_ASYNC_BIT   = 3;
	localparam int CTRL_RIDMASK_BIT = 4;
	localparam int CTRL_WIDTH       = 5;
	localparam logic [4:0] CTRL_RESET = 5'h04;

	localparam int LATCH_RID_BIT     = 0;
	localparam int STATUS_PEND_BIT   = 8;
	localparam int STATUS_DIR_BIT    = 9;

	localparam int CMD_LINE_LSB = 0;
	localparam int CMD_VBUS_LSB = 2;
	localparam int CMD_EVT_LSB  = 4;
	localparam int CMD_ID_BIT   = 6;
	localparam int CMD_ALT_BIT  = 7;

	localparam logic [1:0] LINE_SE0 = 2'h0;
	localparam logic [1:0] LINE_J   = 2'h1;
	localparam logic [1:0] LINE_K   = 2'h2;

	localparam logic [1:0] VBUS_BELOW_END  = 2'h0;
	localparam logic [1:0] VBUS_END_TO_SES = 2'h1;
	localparam logic [1:0] VBUS_SES_TO_VLD = 2'h2;
	localparam logic [1:0] VBUS_ABOVE_VLD  = 2'h3;

	localparam logic [1:0] EVT_NONE    = 2'h0;
	localparam logic [1:0] EVT_ACTIVE  = 2'h1;
	localparam logic [1:0] EVT_ERROR   = 2'h3;
	localparam logic [1:0] EVT_HOST_DISCONNECT_EVENT = 2'h2;

	typedef enum logic [5:0] {
		ST_START = 6'h01,
		ST_IDLE  = 6'h02,
		ST_TURN  = 6'h04,
		ST_SEND  = 6'h08,
		ST_RECV  = 6'h10,
		ST_ASYNC = 6'h20
	} urcg_state_t;
endpackage

// file: src/urcg_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes each bit is an independent level; no word coherence is offered.
module urcg_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} urcg_sync_t;

	urcg_sync_t s_reg;
	urcg_sync_t s_next;

	always_comb begin
		s_next    = s_reg;
		s_next.s1 = d_in;
		s_next.s2 = s_reg.s1;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q_out = s_reg.s2;
endmodule // urcg_sync

// file: testbench/tb.sv
// Self-checking bench for the status byte generator and its APB registers.
// Assumes the link model answers on the byte bus and the bench drives APB.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, dp = 1, dm = 0, sq = 0, se = 0, sv = 1, vv = 1;
	logic idp = 1, rxa = 0, rxe = 0, rxv = 0, hd = 0, cdone = 0;
	logic psel = 0, pen = 0, pwr = 0, rdy, serr, dir, nxt, oe, stp, txb;
	logic [7:0] rxd = 8'h00, pa = 8'h00, dout, din, lastb, lastrx;
	logic [31:0] pwd = 32'h0, prd, rv;
	logic [15:0] cnt, mark;
	logic re;
	int fail_count = 0;
	int comparisons = 0;

	always #10 clk = ~clk;

	urcg_main u_urcg_main (.clk_in(clk), .rst_in(rst), .stp_in(stp),
		.data_in(din), .dir_out(dir), .nxt_out(nxt), .data_out(dout),
		.data_oe_out(oe), .dp_se_in(dp), .dm_se_in(dm), .squelch_in(sq),
		.session_end_flag_in(se), .session_valid_flag_in(sv),
		.vbus_valid_flag_in(vv), .id_in(idp), .rx_active_in(rxa),
		.rx_error_in(rxe), .rx_data_valid_in(rxv), .rx_data_in(rxd),
		.host_disconnect_event_in(hd), .tx_busy_in(txb),
		.id_resistance_conversion_done_in(cdone), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.prdata_out(prd), .pready_out(rdy), .pslverr_out(serr));

	urcg_link_model u_urcg_link_model (.clk_in(clk), .rst_in(rst),
		.dir_in(dir), .nxt_in(nxt), .oe_in(oe), .data_in(dout),
		.stp_out(stp), .data_out(din), .tx_busy_out(txb),
		.byte_cnt_out(cnt), .last_byte_out(lastb), .last_rx_out(lastrx));

	task automatic print_verdict();
		if (fail_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= wd;
		@(posedge clk);
		pen <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (rdy !== 1'b1 && i < 20);
		rv = prd;
		re = serr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (i >= 20) begin
			fail_count++;
			print_verdict();
		end
	endtask

	function automatic logic [7:0] mk(input int a, i,
		input logic [1:0] e, v, l);
		return {a[0], i[0], e, v, l};
	endfunction

	// Waits long enough for synchroniser, scheduling and turnaround.
	task automatic expect_byte(input string nm, input logic [7:0] exp);
		repeat (30) @(posedge clk);
		check({nm, " sent"}, {31'h0, cnt != mark}, 32'h1);
		check(nm, {24'h0, lastb}, {24'h0, exp});
	endtask

	initial begin
		repeat (5) @(posedge clk);
		check("dir in reset", {31'h0, dir}, 32'h1);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		mark = 16'h0;
		apb(1'b0, 8'h00, 32'h0);
		check("ctrl reset", rv, 32'h4);
		expect_byte("startup", 8'h4d);
		for (int k = 0; k < 5; k++) begin
			mark = cnt;
			dp <= k[0] | k[2];
			dm <= k[1];
			expect_byte("line", mk(0, 1, 2'h0, 2'h3, 2'(k % 4) | 2'(k / 4)));
		end
		for (int k = 0; k < 4; k++) begin
			mark = cnt;
			{se, sv, vv} <= (k == 0) ? 3'h4 : (k == 1) ? 3'h0 :
				(k == 2) ? 3'h2 : 3'h3;
			expect_byte("vbus", mk(0, 1, 2'h0, 2'(k), 2'h1));
		end
		mark = cnt;
		idp <= 1'b0;
		expect_byte("id low", mk(0, 0, 2'h0, 2'h3, 2'h1));
		mark = cnt;
		idp <= 1'b1;
		expect_byte("id high", 8'h4d);
		mark = cnt;
		hd <= 1'b1;
		expect_byte("disconnect", mk(0, 1, 2'h2, 2'h3, 2'h1));
		mark = cnt;
		hd <= 1'b0;
		expect_byte("no event", 8'h4d);
		mark = cnt;
		dp <= 1'b0;
		dm <= 1'b1;
		rxa <= 1'b1;
		expect_byte("rx active", mk(0, 1, 2'h1, 2'h3, 2'h2));
		check("rx dir", {31'h0, dir}, 32'h1);
		rxe <= 1'b1;
		expect_byte("rx error", mk(0, 1, 2'h3, 2'h3, 2'h2));
		rxv <= 1'b1;
		rxd <= 8'h5a;
		@(posedge clk);
		rxv <= 1'b0;
		rxe <= 1'b0;
		rxa <= 1'b0;
		expect_byte("rx held", mk(0, 1, 2'h1, 2'h3, 2'h2));
		check("rx data", {24'h0, lastrx}, 32'h5a);
		mark = cnt;
		dp <= 1'b1;
		dm <= 1'b0;
		expect_byte("rx done", 8'h4d);
		check("rx end dir", {31'h0, dir}, 32'h0);
		apb(1'b1, 8'h00, 32'h5);
		mark = cnt;
		sq <= 1'b1;
		expect_byte("squelch", mk(0, 1, 2'h0, 2'h3, 2'h0));
		u_urcg_link_model.tx_begin();
		mark = cnt;
		sq <= 1'b0;
		repeat (30) @(posedge clk);
		check("tx blocked", {16'h0, cnt}, {16'h0, mark});
		u_urcg_link_model.tx_end();
		expect_byte("after tx", mk(0, 1, 2'h0, 2'h3, 2'h1));
		apb(1'b1, 8'h00, 32'hc);
		repeat (10) @(posedge clk);
		check("async dir", {31'h0, dir}, 32'h1);
		mark = cnt;
		apb(1'b1, 8'h00, 32'h14);
		expect_byte("async exit", 8'h4d);
		mark = cnt;
		cdone <= 1'b1;
		@(posedge clk);
		cdone <= 1'b0;
		expect_byte("alt int", 8'hcd);
		apb(1'b0, 8'h08, 32'h0);
		check("latch set", rv, 32'h1);
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b0, 8'h08, 32'h0);
		check("latch clear", rv, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		check("unmapped err", {31'h0, re}, 32'h1);
		check("unmapped data", rv, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		check("ctrl readback", rv, 32'h14);
		print_verdict();
	end
endmodule // tb

// file: testbench/urcg_link_model.sv
// Link controller model on the far side of the 8-bit status bus.
// Assumes the bench calls tx_begin and tx_end only while dir is low.
module urcg_link_model (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        dir_in,
	input  wire logic        nxt_in,
	input  wire logic        oe_in,
	input  wire logic  [7:0] data_in,
	output logic             stp_out,
	output logic       [7:0] data_out,
	output logic             tx_busy_out,
	output logic      [15:0] byte_cnt_out,
	output logic       [7:0] last_byte_out,
	output logic       [7:0] last_rx_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] drv = 8'h00;

	initial begin
		stp_out = 1'b0;
		tx_busy_out = 1'b0;
	end
	// A released bus shows the inverse of our last value, never a fake idle.
	assign data_out = dir_in ? ~drv : drv;

	// Bytes are taken only once the device drives, after turnaround.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			byte_cnt_out <= 16'h0;
			last_byte_out <= 8'h00;
			last_rx_out <= 8'h00;
		end else if (dir_in && oe_in && !nxt_in) begin
			byte_cnt_out <= byte_cnt_out + 16'h1;
			last_byte_out <= data_in;
		end else if (dir_in && oe_in) begin
			last_rx_out <= data_in;
		end
	end

	task automatic tx_begin();
		@(posedge clk_in);
		tx_busy_out <= 1'b1;
		drv <= 8'h40;
	endtask

	task automatic tx_end();
		@(posedge clk_in);
		drv <= 8'h00;
		stp_out <= 1'b1;
		@(posedge clk_in);
		stp_out <= 1'b0;
		tx_busy_out <= 1'b0;
	endtask
endmodule // urcg_link_model
